// ---- rtl/gsc_pkg.sv ----
// gsc_pkg: register map, field layout, reset values and codes of the
// gear/standby clock controller.
// assumes a 32-bit APB slave with byte addresses.
package gsc_pkg;
	// register byte addresses
	localparam logic [7:0] GSC_ADDR_STBY = 8'h00;
	localparam logic [7:0] GSC_ADDR_GEAR = 8'h04;
	localparam logic [7:0] GSC_ADDR_WDCTL = 8'h08;
	localparam logic [7:0] GSC_ADDR_WDPOST = 8'h0C;
	localparam logic [7:0] GSC_ADDR_STAT = 8'h10;
	// standby control fields
	localparam int GSC_STBY_STOP_BIT = 7;
	localparam int GSC_STBY_SLEEP_BIT = 6;
	// gear control fields
	localparam int GSC_GEAR_CPU_LSB = 6;
	localparam int GSC_GEAR_PER_LSB = 2;
	localparam int GSC_GEAR_HALF_BIT = 0;
	localparam logic [1:0] GSC_CPU_RATIO_RST = 2'h3;
	localparam logic [1:0] GSC_PER_RATIO_RST = 2'h3;
	localparam logic GSC_HALF_SEL_RST = 1'b0;
	// watchdog fields and codes
	localparam int GSC_WD_SEL_LSB = 0;
	localparam logic [1:0] GSC_WD_SEL_RST = 2'h0;
	localparam logic [7:0] GSC_WD_KEY1 = 8'hA5;
	localparam logic [7:0] GSC_WD_KEY2 = 8'h5A;
	localparam int GSC_TB_W = 20;
	localparam int GSC_TAP_BASE = 12;
	// status fields
	localparam int GSC_STAT_WDACT_BIT = 4;
	localparam int GSC_STAT_IRQ_BIT = 5;
	localparam int GSC_STAT_WDRST_BIT = 6;
	// oscillation stabilization wait, in oscillator cycles
	localparam int GSC_OSC_WAIT_CYC = 16384;
	localparam int GSC_WAIT_W = 16;
	typedef enum logic [2:0] {
		GSC_ST_RESET,
		GSC_ST_OSCWAIT,
		GSC_ST_RESTART,
		GSC_ST_RUN,
		GSC_ST_SLEEP,
		GSC_ST_STOP
	} gsc_state_t;
endpackage

// ---- rtl/gsc_gear.sv ----
// gsc_gear: source select and the two clock dividers, issued as ticks.
// assumes the oscillator clock drives clk; ratio codes come from registers.
`timescale 1ns/1ps
module gsc_gear (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// settings
	input wire logic half_sel,
	input wire logic [1:0] cpu_ratio,
	input wire logic [1:0] per_ratio,
	// ticks
	output logic src_tick,
	output logic cpu_tick,
	output logic per_tick
);
	typedef struct packed {
		logic half;
		logic [2:0] cnt;
		logic src;
		logic cpu;
		logic per;
	} gsc_gear_t;
	gsc_gear_t cur, next_cur;

	// code 00 f, 01 f/2, 10 f/4, 11 f/8
	function automatic logic ratio_hit(input logic [2:0] c, input logic [1:0] r);
		logic [2:0] m;
		m = 3'h7 >> (2'h3 - r);
		return (c & m) == 3'h0;
	endfunction

	always_comb begin
		logic s;
		s = !half_sel || cur.half; // RQ7
		next_cur = cur;
		next_cur.half = !cur.half;
		// one shared count keeps both domains edge aligned
		if (s) begin
			next_cur.cnt = cur.cnt + 3'h1; // RQ8
		end
		next_cur.src = s;
		next_cur.cpu = s && ratio_hit(cur.cnt, cpu_ratio); // RQ6 RQ9
		next_cur.per = s && ratio_hit(cur.cnt, per_ratio); // RQ6 RQ10
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign src_tick = cur.src;
	assign cpu_tick = cur.cpu;
	assign per_tick = cur.per;
endmodule

// ---- rtl/gsc_wdog.sv ----
// gsc_wdog: watchdog interval lock, postpone key sequence and reset flop.
// assumes tap_fall is a one-cycle pulse on a falling timebase tap.
`timescale 1ns/1ps
module gsc_wdog (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic soft_clr,
	// control writes
	input wire logic ctl_wr,
	input wire logic [1:0] ctl_sel,
	input wire logic post_wr,
	input wire logic [7:0] post_data,
	input wire logic tap_fall,
	// state
	output logic active,
	output logic [1:0] sel,
	output logic reset_req
);
	import gsc_pkg::*;
	typedef struct packed {
		logic act;
		logic [1:0] sel;
		logic armed;
		logic caught;
		logic req;
	} gsc_wdog_t;
	gsc_wdog_t cur, next_cur;

	always_comb begin
		next_cur = cur;
		next_cur.req = 1'b0;
		if (ctl_wr && !cur.act) begin
			next_cur.act = 1'b1; // RQ17
			next_cur.sel = ctl_sel; // RQ17
		end
		if (post_wr) begin
			if (post_data == GSC_WD_KEY1) begin
				next_cur.armed = 1'b1;
			end else if (post_data == GSC_WD_KEY2 && cur.armed) begin
				next_cur.armed = 1'b0;
				next_cur.caught = 1'b0; // RQ16
			end else begin
				next_cur.armed = 1'b0; // RQ19
			end
		end
		// a tap edge wins over a same-cycle postpone
		if (cur.act && tap_fall) begin
			if (cur.caught) begin
				next_cur.req = 1'b1; // RQ18 RQ16
				next_cur.caught = 1'b0;
			end else begin
				next_cur.caught = 1'b1; // RQ18
			end
		end
		if (soft_clr) begin
			next_cur = '0;
			next_cur.sel = GSC_WD_SEL_RST;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign active = cur.act;
	assign sel = cur.sel;
	assign reset_req = cur.req;
endmodule

// ---- rtl/gsc_top.sv ----
// gsc_top: standby state machine, gear control and watchdog behind APB.
// assumes CLOCK is the oscillator clock; interrupt, reset and data pins
// arrive asynchronously and are synchronized here.
//
// Function
// RQ1: stabilization end resumes internal clocks
// RQ2: reset forces reset state, release resumes
// RQ3: sleep request bit moves run to sleep
// RQ4: stop request bit moves run to stop
// RQ5: interrupt or NMI wakes sleep or stop
// RQ6: independent CPU and peripheral dividers
// RQ7: select bit picks half-rate or direct source
// RQ8: source switch hits both domains together
// RQ9: CPU ratio codes f, f/2, f/4, f/8
// RQ10: peripheral ratio same coding, independent
// RQ11: gear fields at bits 7:6, 3:2, 0
// RQ12: software avoids disabled ratio pairs
// RQ13: software sets one wait before 00/00
// RQ14: serial and pulse units unreliable at half-rate
// RQ15: servo sync to oscillator, serial to peripheral
// RQ16: missing A5 then 5A raises watchdog reset
// RQ17: first control write fixes watchdog interval
// RQ18: reset if flop uncleared by second edge
// RQ19: non-5A write after A5 voids it
// RQ20: stop wake restarts peripheral, bus, CPU
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module gsc_top #(
	parameter int OSC_WAIT_CYC = gsc_pkg::GSC_OSC_WAIT_CYC
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// wake and reset pins
	input wire logic RESET_IN,
	input wire logic PERIPH_IRQ,
	input wire logic NMI_IN,
	// peripheral inputs to be synchronized
	input wire logic [2:0] SERVO_IN,
	input wire logic [2:0] SERIAL_IN,
	output logic [2:0] SERVO_SYNC,
	output logic [2:0] SERIAL_SYNC,
	// clock enables and status
	output logic OSC_EN,
	output logic CPU_CLK_EN,
	output logic BUS_CLK_EN,
	output logic PERIPH_CLK_EN,
	output logic CORE_RESET,
	output logic WDT_RESET
);
	import gsc_pkg::*;

	localparam logic [GSC_WAIT_W-1:0] WAIT_LAST = GSC_WAIT_W'(OSC_WAIT_CYC - 1);

	typedef struct packed {
		gsc_state_t st;
		logic [1:0] phase;
		logic [GSC_WAIT_W-1:0] wait_cnt;
		logic [1:0] cpu_ratio;
		logic [1:0] per_ratio;
		logic half_sel;
		logic wd_reset_seen;
		logic [GSC_TB_W-1:0] tb;
		logic tap_prev;
		logic [2:0] rst_sync;
		logic [1:0] irq_sync;
		logic [1:0] nmi_sync;
		logic [2:0] servo_s1;
		logic [2:0] servo_s2;
		logic [2:0] serial_s1;
		logic [2:0] serial_s2;
		logic [2:0] serial_hold;
		logic [31:0] rdata;
		logic osc_en;
		logic cpu_en;
		logic bus_en;
		logic per_en;
	} gsc_top_t;
	gsc_top_t cur, next_cur;

	logic src_tick, cpu_tick, per_tick;
	logic wd_active, wd_req;
	logic [1:0] wd_sel;
	logic wr_en, access, mapped, soft_clr;
	logic ctl_wr, post_wr, tap_fall, tap_now;

	function automatic logic addr_mapped(input logic [7:0] a);
		return a == GSC_ADDR_STBY || a == GSC_ADDR_GEAR || a == GSC_ADDR_WDCTL ||
			a == GSC_ADDR_WDPOST || a == GSC_ADDR_STAT;
	endfunction

	// apb handshake: zero wait states in the access phase
	assign access = PSEL && PENABLE;
	assign mapped = addr_mapped(PADDR);
	assign PREADY = access;
	assign PSLVERR = access && !mapped;
	assign wr_en = access && PWRITE && mapped;
	assign ctl_wr = wr_en && PADDR == GSC_ADDR_WDCTL;
	assign post_wr = wr_en && PADDR == GSC_ADDR_WDPOST;
	assign soft_clr = cur.st == GSC_ST_RESET;

	// watchdog tap on the timebase, four intervals two octaves apart
	assign tap_now = cur.tb[GSC_TAP_BASE + 2 * int'(wd_sel)];
	assign tap_fall = cur.tap_prev && !tap_now;

	gsc_gear u_gear (
		.clk(CLOCK),
		.rst(RST),
		.half_sel(cur.half_sel),
		.cpu_ratio(cur.cpu_ratio),
		.per_ratio(cur.per_ratio),
		.src_tick(src_tick),
		.cpu_tick(cpu_tick),
		.per_tick(per_tick)
	);

	gsc_wdog u_wdog (
		.clk(CLOCK),
		.rst(RST),
		.soft_clr(soft_clr),
		.ctl_wr(ctl_wr),
		.ctl_sel(PWDATA[GSC_WD_SEL_LSB +: 2]),
		.post_wr(post_wr),
		.post_data(PWDATA[7:0]),
		.tap_fall(tap_fall),
		.active(wd_active),
		.sel(wd_sel),
		.reset_req(wd_req)
	);

	always_comb begin
		logic wake, rst_src, stop_wr, sleep_wr;
		wake = 1'b0;
		rst_src = 1'b0;
		stop_wr = 1'b0;
		sleep_wr = 1'b0;
		next_cur = cur;

		// synchronizers: stage one feeds stage two only
		next_cur.rst_sync = {cur.rst_sync[1:0], RESET_IN};
		next_cur.irq_sync = {cur.irq_sync[0], PERIPH_IRQ};
		next_cur.nmi_sync = {cur.nmi_sync[0], NMI_IN};
		next_cur.servo_s1 = SERVO_IN;
		next_cur.servo_s2 = cur.servo_s1; // RQ15
		next_cur.serial_s1 = SERIAL_IN;
		next_cur.serial_s2 = cur.serial_s1;
		if (per_tick) begin
			next_cur.serial_hold = cur.serial_s2; // RQ15
		end

		wake = cur.irq_sync[1] || cur.nmi_sync[1];
		rst_src = cur.rst_sync[2] || wd_req;
		if (wd_req) begin
			next_cur.wd_reset_seen = 1'b1;
		end

		// timebase runs on the source clock
		if (src_tick) begin
			next_cur.tb = cur.tb + GSC_TB_W'(1);
		end
		next_cur.tap_prev = tap_now;

		// register writes
		if (wr_en && PADDR == GSC_ADDR_GEAR) begin
			next_cur.cpu_ratio = PWDATA[GSC_GEAR_CPU_LSB +: 2]; // RQ11
			next_cur.per_ratio = PWDATA[GSC_GEAR_PER_LSB +: 2]; // RQ11
			next_cur.half_sel = PWDATA[GSC_GEAR_HALF_BIT]; // RQ11
		end
		if (wr_en && PADDR == GSC_ADDR_STAT && PWDATA[GSC_STAT_WDRST_BIT]) begin
			next_cur.wd_reset_seen = wd_req;
		end
		if (wr_en && PADDR == GSC_ADDR_STBY) begin
			stop_wr = PWDATA[GSC_STBY_STOP_BIT];
			sleep_wr = !PWDATA[GSC_STBY_STOP_BIT] && PWDATA[GSC_STBY_SLEEP_BIT];
		end

		// read data captured in the setup phase
		if (PSEL && !PENABLE) begin
			next_cur.rdata = '0;
			case (PADDR)
				GSC_ADDR_GEAR: begin
					next_cur.rdata[GSC_GEAR_CPU_LSB +: 2] = cur.cpu_ratio;
					next_cur.rdata[GSC_GEAR_PER_LSB +: 2] = cur.per_ratio;
					next_cur.rdata[GSC_GEAR_HALF_BIT] = cur.half_sel;
				end
				GSC_ADDR_WDCTL: begin
					next_cur.rdata[GSC_WD_SEL_LSB +: 2] = wd_sel;
				end
				GSC_ADDR_STAT: begin
					next_cur.rdata[2:0] = cur.st;
					next_cur.rdata[GSC_STAT_WDACT_BIT] = wd_active;
					next_cur.rdata[GSC_STAT_IRQ_BIT] = wake;
					next_cur.rdata[GSC_STAT_WDRST_BIT] = cur.wd_reset_seen;
				end
				default: begin
					next_cur.rdata = '0;
				end
			endcase
		end

		// standby state machine
		case (cur.st)
			GSC_ST_RESET: begin
				next_cur.wait_cnt = '0;
				if (!rst_src) begin
					next_cur.st = GSC_ST_OSCWAIT; // RQ2
				end
			end
			GSC_ST_OSCWAIT: begin
				next_cur.wait_cnt = cur.wait_cnt + GSC_WAIT_W'(1);
				if (cur.wait_cnt == WAIT_LAST) begin
					next_cur.st = GSC_ST_RESTART; // RQ1
					next_cur.phase = 2'h0;
				end
			end
			GSC_ST_RESTART: begin
				// peripheral, then bus, then cpu
				next_cur.phase = cur.phase + 2'h1; // RQ20
				if (cur.phase == 2'h2) begin
					next_cur.st = GSC_ST_RUN; // RQ1
				end
			end
			GSC_ST_RUN: begin
				// a pending interrupt cancels the standby write
				if (stop_wr && !wake) begin
					next_cur.st = GSC_ST_STOP; // RQ4
				end else if (sleep_wr && !wake) begin
					next_cur.st = GSC_ST_SLEEP; // RQ3
				end
			end
			GSC_ST_SLEEP: begin
				if (wake) begin
					next_cur.st = GSC_ST_RUN; // RQ5
				end
			end
			GSC_ST_STOP: begin
				if (wake) begin
					next_cur.st = GSC_ST_OSCWAIT; // RQ5
					next_cur.wait_cnt = '0;
				end
			end
			default: begin
				next_cur.st = GSC_ST_RESET;
			end
		endcase

		if (rst_src) begin
			next_cur.st = GSC_ST_RESET; // RQ2
		end
		if (cur.st == GSC_ST_RESET) begin
			next_cur.cpu_ratio = GSC_CPU_RATIO_RST;
			next_cur.per_ratio = GSC_PER_RATIO_RST;
			next_cur.half_sel = GSC_HALF_SEL_RST;
		end

		// clock gating from the next state
		next_cur.osc_en = next_cur.st != GSC_ST_STOP;
		next_cur.per_en = next_cur.st == GSC_ST_RUN || next_cur.st == GSC_ST_SLEEP ||
			next_cur.st == GSC_ST_RESTART; // RQ20
		next_cur.bus_en = next_cur.st == GSC_ST_RUN ||
			(next_cur.st == GSC_ST_RESTART && next_cur.phase != 2'h0); // RQ20
		next_cur.cpu_en = next_cur.st == GSC_ST_RUN; // RQ20
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			cur <= '0;
			cur.st <= GSC_ST_RESET; // RQ2
			cur.cpu_ratio <= GSC_CPU_RATIO_RST;
			cur.per_ratio <= GSC_PER_RATIO_RST;
			cur.half_sel <= GSC_HALF_SEL_RST;
			cur.osc_en <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	assign PRDATA = cur.rdata;
	assign SERVO_SYNC = cur.servo_s2;
	assign SERIAL_SYNC = cur.serial_hold;
	assign OSC_EN = cur.osc_en;
	assign CPU_CLK_EN = cur.cpu_en && cpu_tick;
	assign BUS_CLK_EN = cur.bus_en && cpu_tick;
	assign PERIPH_CLK_EN = cur.per_en && per_tick;
	assign CORE_RESET = cur.st == GSC_ST_RESET;
	assign WDT_RESET = wd_req;
endmodule

// ---- dv/gsc_top_monitor.sv ----
// gsc_top_monitor: port-level checks of the clock controller.
// assumes it is bound into gsc_top and sees only its ports.
`timescale 1ns/1ps
module gsc_top_monitor #(
	parameter int OSC_WAIT_CYC = 8
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// apb answer
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// pins
	input wire logic [2:0] SERVO_IN,
	input wire logic [2:0] SERVO_SYNC,
	input wire logic OSC_EN,
	input wire logic CPU_CLK_EN,
	input wire logic BUS_CLK_EN,
	input wire logic PERIPH_CLK_EN,
	input wire logic CORE_RESET,
	input wire logic WDT_RESET
);
	logic [1:0] age;
	// the sync chain is only comparable once it has refilled after reset
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	property p_rdy; PSEL && PENABLE |-> PREADY; endproperty
	property p_err; PSLVERR |-> PSEL && PENABLE; endproperty
	property p_wait; $fell(CORE_RESET) |-> (!CPU_CLK_EN && !PERIPH_CLK_EN) [*8]; endproperty
	property p_rst; CORE_RESET |-> !CPU_CLK_EN && !BUS_CLK_EN && !PERIPH_CLK_EN; endproperty
	property p_stop; !OSC_EN |-> !CPU_CLK_EN && !BUS_CLK_EN && !PERIPH_CLK_EN; endproperty
	property p_bus; CPU_CLK_EN |-> BUS_CLK_EN; endproperty
	property p_wdp; WDT_RESET |=> !WDT_RESET; endproperty
	property p_wdr; WDT_RESET |-> ##[1:4] CORE_RESET; endproperty
	property p_servo; age == 2'h3 |-> SERVO_SYNC == $past(SERVO_IN, 2); endproperty
	a_rdy: assert property (p_rdy) else $error("pready missing in access");
	a_err: assert property (p_err) else $error("pslverr outside access");
	a_wait: assert property (p_wait) else $error("clock during stabilization");
	a_rst: assert property (p_rst) else $error("clock during reset");
	a_stop: assert property (p_stop) else $error("clock while stopped");
	a_bus: assert property (p_bus) else $error("cpu tick without bus tick");
	a_wdp: assert property (p_wdp) else $error("watchdog reset not a pulse");
	a_wdr: assert property (p_wdr) else $error("watchdog reset not taken");
	a_servo: assert property (p_servo) else $error("servo sync wrong");
	c_wd: cover property (WDT_RESET);
	c_stop: cover property (!OSC_EN);
	c_err: cover property (PSLVERR);
endmodule
bind gsc_top gsc_top_monitor #(.OSC_WAIT_CYC(OSC_WAIT_CYC)) u_mon (.CLOCK, .RST, .PSEL,
	.PENABLE, .PREADY, .PSLVERR, .SERVO_IN, .SERVO_SYNC, .OSC_EN, .CPU_CLK_EN, .BUS_CLK_EN,
	.PERIPH_CLK_EN, .CORE_RESET, .WDT_RESET);

// ---- dv/tb_top.sv ----
// tb_top: directed scenarios for the clock controller over APB and pins.
// assumes the bound monitor; stabilization wait shortened to 8 cycles.
`timescale 1ns/1ps
module tb_top;
	import gsc_pkg::*;
	localparam int WAITC = 8;
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic RESET_IN = 1'b0;
	logic PERIPH_IRQ = 1'b0;
	logic NMI_IN = 1'b0;
	logic [2:0] SERVO_IN = 3'h0;
	logic [2:0] SERIAL_IN = 3'h0;
	logic [31:0] PRDATA;
	logic PREADY, PSLVERR, OSC_EN, CPU_CLK_EN, BUS_CLK_EN, PERIPH_CLK_EN, CORE_RESET;
	logic WDT_RESET;
	logic [2:0] SERVO_SYNC, SERIAL_SYNC;
	int num_errors = 0;
	int n_checks = 0;
	int wd_cnt = 0;
	logic [31:0] rd;
	logic er;
	always #2.5 CLOCK = ~CLOCK;
	always @(posedge CLOCK) begin
		SERVO_IN <= SERVO_IN + 3'h1;
		if (WDT_RESET === 1'b1) wd_cnt <= wd_cnt + 1;
	end
	gsc_top #(.OSC_WAIT_CYC(WAITC)) u_dut (.CLOCK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PRDATA, .PREADY, .PSLVERR, .RESET_IN, .PERIPH_IRQ, .NMI_IN, .SERVO_IN,
		.SERIAL_IN, .SERVO_SYNC, .SERIAL_SYNC, .OSC_EN, .CPU_CLK_EN, .BUS_CLK_EN,
		.PERIPH_CLK_EN, .CORE_RESET, .WDT_RESET);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLOCK);
			k++;
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		chk("pready_wait", 32'(k), 32'h1);
	endtask
	task automatic cnt(input int n, output int c, output int p, output int b);
		c = 0;
		p = 0;
		b = 0;
		repeat (n) begin
			@(posedge CLOCK);
			c += int'(CPU_CLK_EN === 1'b1);
			p += int'(PERIPH_CLK_EN === 1'b1);
			b += int'(BUS_CLK_EN === 1'b1);
		end
	endtask
	// waits for the first cpu tick; returns cycles waited, set if periph ticked before or with it
	task automatic to_cpu(output int n, output logic sp);
		n = 0;
		sp = 1'b0;
		while (CPU_CLK_EN !== 1'b1 && n < 300) begin
			@(posedge CLOCK);
			n++;
			if (PERIPH_CLK_EN === 1'b1) sp = 1'b1;
		end
	endtask
	task automatic t_boot();
		int n;
		logic sp;
		to_cpu(n, sp);
		chk("boot_min", 32'(n >= WAITC + 3), 32'h1);
		chk("boot_max", 32'(n <= WAITC + 24), 32'h1);
		chk("boot_order", 32'(sp), 32'h1);
		apb(1'b0, GSC_ADDR_STAT, 32'h0);
		chk("run_state", 32'(rd[2:0]), 32'h3);
		apb(1'b0, GSC_ADDR_GEAR, 32'h0);
		chk("gear_rst", rd, 32'h000000CC);
		chk("serial_sync", 32'(SERIAL_SYNC), 32'h5);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped_rd", rd, 32'h0);
		chk("unmapped_err", 32'(er), 32'h1);
	endtask
	task automatic t_gear();
		logic [7:0] g [9] = '{8'hCC, 8'h80, 8'h40, 8'h44, 8'h88, 8'hC4, 8'h00, 8'h01, 8'h41};
		int ec [9] = '{8, 16, 32, 32, 16, 8, 64, 32, 16};
		int ep [9] = '{8, 64, 64, 32, 16, 32, 64, 32, 32};
		int c;
		int p;
		int b;
		// only enabled ratio pairs; 00/00 assumes the wait state is set elsewhere
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, GSC_ADDR_GEAR, 32'(g[i]));
			repeat (4) @(posedge CLOCK);
			cnt(64, c, p, b);
			chk("cpu_ticks", 32'(c), 32'(ec[i]));
			chk("bus_ticks", 32'(b), 32'(ec[i]));
			chk("per_ticks", 32'(p), 32'(ep[i]));
			apb(1'b0, GSC_ADDR_GEAR, 32'h0);
			chk("gear_rd", rd, 32'(g[i]));
		end
	endtask
	task automatic t_sleep();
		int c;
		int p;
		int b;
		apb(1'b1, GSC_ADDR_GEAR, 32'hCC);
		apb(1'b1, GSC_ADDR_STBY, 32'h40);
		apb(1'b0, GSC_ADDR_STAT, 32'h0);
		chk("sleep_state", 32'(rd[2:0]), 32'h4);
		cnt(32, c, p, b);
		chk("sleep_cpu", 32'(c), 32'h0);
		chk("sleep_bus", 32'(b), 32'h0);
		chk("sleep_per", 32'(p), 32'h4);
		PERIPH_IRQ <= 1'b1;
		repeat (8) @(posedge CLOCK);
		PERIPH_IRQ <= 1'b0;
		repeat (8) @(posedge CLOCK);
		apb(1'b0, GSC_ADDR_STAT, 32'h0);
		chk("irq_wake", 32'(rd[2:0]), 32'h3);
	endtask
	task automatic t_stop();
		int n;
		logic sp;
		apb(1'b1, GSC_ADDR_GEAR, 32'h01);
		apb(1'b1, GSC_ADDR_STBY, 32'h80);
		apb(1'b0, GSC_ADDR_STAT, 32'h0);
		chk("stop_state", 32'(rd[2:0]), 32'h5);
		chk("stop_osc", 32'(OSC_EN), 32'h0);
		NMI_IN <= 1'b1;
		to_cpu(n, sp);
		NMI_IN <= 1'b0;
		chk("nmi_wake", 32'(n >= WAITC && n < 300), 32'h1);
		chk("wake_order", 32'(sp), 32'h1);
		chk("wake_osc", 32'(OSC_EN), 32'h1);
		repeat (8) @(posedge CLOCK);
	endtask
	task automatic t_rstin();
		int n;
		logic sp;
		apb(1'b1, GSC_ADDR_GEAR, 32'h41);
		RESET_IN <= 1'b1;
		repeat (8) @(posedge CLOCK);
		chk("pin_reset", 32'(CORE_RESET), 32'h1);
		RESET_IN <= 1'b0;
		to_cpu(n, sp);
		apb(1'b0, GSC_ADDR_GEAR, 32'h0);
		chk("pin_gear", rd, 32'h000000CC);
	endtask
	task automatic t_wdog();
		int n;
		logic sp;
		int w0;
		apb(1'b1, GSC_ADDR_WDCTL, 32'h0);
		// a longer interval here would keep the bad-key phase from resetting in time
		apb(1'b1, GSC_ADDR_WDCTL, 32'h3);
		apb(1'b0, GSC_ADDR_STAT, 32'h0);
		chk("wd_active", 32'(rd[4]), 32'h1);
		apb(1'b0, GSC_ADDR_WDCTL, 32'h0);
		chk("wd_sel_lock", rd, 32'h0);
		w0 = wd_cnt;
		repeat (8) begin
			apb(1'b1, GSC_ADDR_WDPOST, 32'hA5);
			apb(1'b1, GSC_ADDR_WDPOST, 32'h5A);
			repeat (4000) @(posedge CLOCK);
		end
		chk("wd_kept", 32'(wd_cnt - w0), 32'h0);
		for (int i = 0; i < 6 && wd_cnt == w0; i++) begin
			apb(1'b1, GSC_ADDR_WDPOST, 32'hA5);
			apb(1'b1, GSC_ADDR_WDPOST, 32'h33);
			apb(1'b1, GSC_ADDR_WDPOST, 32'h5A);
			repeat (4000) @(posedge CLOCK);
		end
		chk("wd_fired", 32'(wd_cnt - w0), 32'h1);
		to_cpu(n, sp);
		apb(1'b0, GSC_ADDR_STAT, 32'h0);
		chk("wd_flag", 32'(rd[6]), 32'h1);
		apb(1'b1, GSC_ADDR_STAT, 32'h40);
		apb(1'b0, GSC_ADDR_STAT, 32'h0);
		chk("wd_flag_clr", 32'(rd[6]), 32'h0);
	endtask
	initial begin
		repeat (8) @(posedge CLOCK);
		RST <= 1'b0;
		SERIAL_IN <= 3'h5;
		t_boot();
		t_gear();
		t_sleep();
		t_stop();
		t_rstin();
		t_wdog();
		end_of_test();
	end
	initial begin
		#450us;
		num_errors++;
		end_of_test();
	end
endmodule
